// file: hdl/tvpa_assembly.sv
// Transmit packet assembly control for one voice connection.
// Assumes the scheduler queue and TDM logic share aclk with this block.
//
// What this block does
// R01: Payload bytes from frames, bearers and rate.
// R02: Accept event only when pointer reached.
// R03: First event discards, arms pointer with offset.
// R04: Invalid structure ignores events, flags untouched.
// R05: Software arms the valid flag last.
// R06: Buffer sizes 512 to 4K, one setting.
// R07: Rate comes from buffer side information.
// R08: Scheduling keeps one coding per packet.
// R09: Frames count samples at every rate.
// R10: Six payload types including comfort noise.
// R11: Zero suppression base disables suppression.
// R12: No suppression with several bearers.
// R13: Data start backs off extra delay frames.
// R14: Timestamp is first byte time plus offset.
// R15: Global time from counter or TDM slots.
// R16: Buffer base ignores bits below size.
// R17: Samples come from the left byte only.
// R18: HDLC and CPU payloads only get wrapped.
// R19: Sequence insert flag picks sequence source.
// R20: Timestamp insert flag adds global time.
// R21: Non-RTP traffic uses transparent settings.
// R22: Check valid, then start-up, then pointer.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
module tvpa_assembly #(
  parameter int PW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PW-1:0] tdm_ptr,
  input wire logic frame_tick,
  input wire logic [31:0] tdm_ts,
  input wire logic ev_valid,
  output logic ev_ready,
  input wire logic ev_hdlc,
  input wire logic ev_cn,
  input wire logic ev_ts_insert,
  input wire logic [31:0] ev_ts,
  input wire logic [2:0] ev_rate,
  output logic pkt_valid,
  output logic pkt_hdlc,
  output logic [15:0] pkt_bytes,
  output logic [31:0] pkt_addr,
  output logic [31:0] pkt_ts,
  output logic [2:0] pkt_pt,
  output logic [15:0] pkt_seq,
  output logic pkt_seq_gen,
  output logic pkt_ss_en
);
  // Configuration and status registers.
  logic [31:0] ctrl_q, ctrl_d, shape_q, shape_d, tsoff_q, tsoff_d, base_q, base_d;
  logic [PW-1:0] next_q, next_d;
  logic [15:0] ssb_q, ssb_d, seq_q, seq_d, acc_q, acc_d, ign_q, ign_d;
  // Internal free-running frame timestamp.
  logic [31:0] fr_q, fr_d;
  // Bus handshake state; address and data may arrive in either order.
  logic awh_q, awh_d, wh_q, wh_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wda_q, wda_d;
  logic [3:0] wst_q, wst_d;
  logic awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [31:0] rd_q, rd_d;
  // Packet descriptor outputs.
  logic pv_q, pv_d, ph_q, ph_d, pg_q, pg_d, ps_q, ps_d;
  logic [15:0] pb_q, pb_d, pq_q, pq_d;
  logic [31:0] pa_q, pa_d, pt_q, pt_d;
  logic [2:0] pp_q, pp_d;
  // Event qualification terms.
  logic fire, go_voice, go_hdlc;
  logic [3:0] bps;
  logic [31:0] bits, gts, mask, start_b;
  logic [PW-1:0] start_f, age;

  assign fire = ev_valid && ev_ready;

  // Applies byte strobes to one stored word.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Next-state logic for bus, configuration, event handling and descriptor.
  always_comb begin
    logic wdo;
    wdo = 1'b0;
    {ctrl_d, shape_d, tsoff_d, base_d} = {ctrl_q, shape_q, tsoff_q, base_q};
    {next_d, ssb_d} = {next_q, ssb_q};
    {seq_d, acc_d, ign_d} = {seq_q, acc_q, ign_q};
    {awh_d, wh_d, awa_d, wda_d, wst_d} = {awh_q, wh_q, awa_q, wda_q, wst_q};
    {bv_d, br_d, arr_d, rv_d, rr_d, rd_d} = {bv_q, br_q, arr_q, rv_q, rr_q, rd_q};
    {ph_d, pb_d, pa_d, pt_d} = {ph_q, pb_q, pa_q, pt_q};
    {pp_d, pq_d, pg_d, ps_d} = {pp_q, pq_q, pg_q, ps_q};
    pv_d = 1'b0;
    // The internal timestamp advances once per TDM frame.
    fr_d = fr_q + {31'h0, frame_tick}; // R15
    gts = ctrl_q[tvpa_pkg::C_TSSRC] ? tdm_ts : fr_q; // R15
    // Bits per sample for each rate; 16 kbps packs four frames a byte.
    unique case (ev_rate) // R07
      tvpa_pkg::R_A40: bps = 4'h5;
      tvpa_pkg::R_A32: bps = 4'h4;
      tvpa_pkg::R_A24: bps = 4'h3;
      tvpa_pkg::R_A16: bps = 4'h2; // R09
      default: bps = 4'h8;
    endcase
    bits = 32'(shape_q[tvpa_pkg::S_FPP +: 8] * shape_q[tvpa_pkg::S_BEAR +: 8]) * 32'(bps); // R01
    // Data starts one packet back, plus the extra delay frames.
    start_f = PW'(next_q - PW'(shape_q[tvpa_pkg::S_FPP +: 8])
      - PW'(shape_q[tvpa_pkg::S_XDLY +: 8])); // R13
    age = PW'(tdm_ptr - start_f);
    // One size setting covers all buffers; low base bits are dropped.
    mask = (32'h0000_0001 << (tvpa_pkg::BUF_MIN_LOG2 + 32'(ctrl_q[tvpa_pkg::C_BSZ +: 2])))
      - 32'h1; // R06 R16
    // Each frame occupies one 16-bit word; the sample is its left byte.
    start_b = (base_q & ~mask) | ((32'(start_f) << 1) & mask); // R16 R17
    go_voice = fire && ctrl_q[tvpa_pkg::C_VALID] && !ev_hdlc && ctrl_q[tvpa_pkg::C_INIT]
      && (tdm_ptr >= next_q); // R02 R22
    go_hdlc = fire && ctrl_q[tvpa_pkg::C_VALID] && ev_hdlc;
    // An event on an unarmed structure leaves every flag as it was.
    if (fire && !ctrl_q[tvpa_pkg::C_VALID]) begin // R04 R22
      ign_d = ign_q + 16'h1;
    end else if (fire && !ev_hdlc && !ctrl_q[tvpa_pkg::C_INIT]) begin // R22
      // Start-up: the stored pointer is an offset; this packet is dropped.
      next_d = PW'(tdm_ptr + next_q); // R03
      ctrl_d[tvpa_pkg::C_INIT] = 1'b1; // R03
      ign_d = ign_q + 16'h1;
    end else if (fire && !ev_hdlc && !go_voice) begin
      ign_d = ign_q + 16'h1; // R02
    end
    if (go_voice) begin
      pv_d = 1'b1;
      ph_d = 1'b0;
      pb_d = 16'((bits + 32'h7) >> 3); // R01
      pa_d = start_b;
      pt_d = gts - 32'(age) + tsoff_q; // R14
      pp_d = ev_cn ? tvpa_pkg::PT_CN : ev_rate; // R10
      ps_d = (ssb_q != 16'h0) && (shape_q[tvpa_pkg::S_BEAR +: 8] == 8'h1); // R11 R12
      pg_d = 1'b1;
      next_d = PW'(next_q + PW'(shape_q[tvpa_pkg::S_FPP +: 8]));
      acc_d = acc_q + 16'h1;
    end else if (go_hdlc) begin
      // Payload passes as is; only headers and RTP fields are touched.
      pv_d = 1'b1; // R18
      ph_d = 1'b1;
      pb_d = 16'h0;
      pa_d = 32'h0;
      pt_d = ev_ts + (ev_ts_insert ? gts : 32'h0) + tsoff_q; // R20
      pp_d = tvpa_pkg::R_PCM;
      ps_d = 1'b0;
      pg_d = ctrl_q[tvpa_pkg::C_SEQINS]; // R19
      acc_d = acc_q + 16'h1;
    end
    if (go_voice || (go_hdlc && ctrl_q[tvpa_pkg::C_SEQINS])) begin
      pq_d = seq_q; // R19
      seq_d = seq_q + 16'h1;
    end else if (go_hdlc) begin
      pq_d = 16'h0;
    end
    // Write channel: hold address and data until both have arrived.
    if (s_axi_awvalid && awr_q) begin
      awh_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_q) begin
      wh_d = 1'b1;
      wda_d = s_axi_wdata;
      wst_d = s_axi_wstrb;
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (awh_q && wh_q && !bv_q) begin
      wdo = 1'b1;
      bv_d = 1'b1;
      awh_d = 1'b0;
      wh_d = 1'b0;
      br_d = tvpa_pkg::RESP_OK;
      unique case (awa_q)
        tvpa_pkg::CTRL_A: begin
          ctrl_d = merge(ctrl_q, wda_q, wst_q) & 32'h0000_003f;
          // A start-up set in the same cycle beats the software clear.
          if (fire && ctrl_q[tvpa_pkg::C_VALID] && !ev_hdlc && !ctrl_q[tvpa_pkg::C_INIT]) begin
            ctrl_d[tvpa_pkg::C_INIT] = 1'b1; // R03
          end
        end
        tvpa_pkg::NEXT_A: next_d = PW'(merge(32'(next_q), wda_q, wst_q));
        tvpa_pkg::SHAPE_A: shape_d = merge(shape_q, wda_q, wst_q) & 32'h00ff_ffff;
        tvpa_pkg::TSOFF_A: tsoff_d = merge(tsoff_q, wda_q, wst_q);
        tvpa_pkg::SSB_A: ssb_d = 16'(merge({16'h0, ssb_q}, wda_q, wst_q));
        tvpa_pkg::BASE_A: base_d = merge(base_q, wda_q, wst_q);
        tvpa_pkg::SEQ_A: seq_d = 16'(merge({16'h0, seq_q}, wda_q, wst_q));
        tvpa_pkg::STAT_A: br_d = tvpa_pkg::RESP_OK;
        default: br_d = tvpa_pkg::RESP_ERR;
      endcase
    end
    awr_d = !awh_d && !bv_d && !wdo;
    wr_d = !wh_d && !bv_d && !wdo;
    // Read channel: one outstanding read, answered the cycle after it is taken.
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    if (s_axi_arvalid && arr_q) begin
      rv_d = 1'b1;
      rr_d = tvpa_pkg::RESP_OK;
      unique case (s_axi_araddr)
        tvpa_pkg::CTRL_A: rd_d = ctrl_q;
        tvpa_pkg::NEXT_A: rd_d = 32'(next_q);
        tvpa_pkg::SHAPE_A: rd_d = shape_q;
        tvpa_pkg::TSOFF_A: rd_d = tsoff_q;
        tvpa_pkg::SSB_A: rd_d = {16'h0, ssb_q};
        tvpa_pkg::BASE_A: rd_d = base_q;
        tvpa_pkg::STAT_A: rd_d = {ign_q, acc_q};
        tvpa_pkg::SEQ_A: rd_d = {16'h0, seq_q};
        default: begin
          rd_d = 32'h0;
          rr_d = tvpa_pkg::RESP_ERR;
        end
      endcase
    end
    arr_d = !rv_d;
  end

  // State registers with synchronous active-low reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ctrl_q, tsoff_q, base_q, fr_q, wda_q, rd_q, pa_q, pt_q} <= '0;
      shape_q <= tvpa_pkg::SHAPE_RST;
      {next_q, ssb_q, seq_q, acc_q, ign_q, pb_q, pq_q} <= '0;
      {awh_q, wh_q, awa_q, wst_q, bv_q, br_q, rv_q, rr_q} <= '0;
      {awr_q, wr_q, arr_q} <= 3'h0;
      {pv_q, ph_q, pg_q, ps_q, pp_q} <= '0;
    end else begin
      {ctrl_q, shape_q, tsoff_q, base_q, fr_q, wda_q, rd_q, pa_q, pt_q} <=
        {ctrl_d, shape_d, tsoff_d, base_d, fr_d, wda_d, rd_d, pa_d, pt_d};
      {next_q, ssb_q, seq_q, acc_q, ign_q, pb_q, pq_q} <=
        {next_d, ssb_d, seq_d, acc_d, ign_d, pb_d, pq_d};
      {awh_q, wh_q, awa_q, wst_q, bv_q, br_q, rv_q, rr_q} <=
        {awh_d, wh_d, awa_d, wst_d, bv_d, br_d, rv_d, rr_d};
      {awr_q, wr_q, arr_q} <= {awr_d, wr_d, arr_d};
      {pv_q, ph_q, pg_q, ps_q, pp_q} <= {pv_d, ph_d, pg_d, ps_d, pp_d};
    end
  end

  // The queue is always drained: each event is judged in one cycle.
  logic evr_q;
  always_ff @(posedge aclk) begin
    evr_q <= aresetn;
  end

  assign ev_ready = evr_q;
  assign {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp} = {awr_q, wr_q, bv_q, br_q};
  assign {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata} = {arr_q, rv_q, rr_q, rd_q};
  assign {pkt_valid, pkt_hdlc, pkt_bytes, pkt_addr, pkt_ts} = {pv_q, ph_q, pb_q, pa_q, pt_q};
  assign {pkt_pt, pkt_seq, pkt_seq_gen, pkt_ss_en} = {pp_q, pq_q, pg_q, ps_q};

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_armed_voice;
    fire && ctrl_q[tvpa_pkg::C_VALID] && !ev_hdlc;
  endsequence

  a_invalid_ignored: assert property ( // R04
    fire && !ctrl_q[tvpa_pkg::C_VALID] && !(awh_q && wh_q) |=> !pkt_valid && $stable(next_q)
      && $stable(ctrl_q[tvpa_pkg::C_INIT]))
    else $error("event on invalid structure had an effect");
  a_startup_arm: assert property ( // R03
    s_armed_voice ##0 !ctrl_q[tvpa_pkg::C_INIT] && !(awh_q && wh_q)
    |=> !pkt_valid && ctrl_q[tvpa_pkg::C_INIT] && next_q == PW'($past(tdm_ptr) + $past(next_q)))
    else $error("start-up did not arm pointer");
  a_ptr_early: assert property ( // R02
    s_armed_voice ##0 ctrl_q[tvpa_pkg::C_INIT] && tdm_ptr < next_q |=> !pkt_valid)
    else $error("early event produced a packet");
  a_voice_bytes: assert property ( // R01
    go_voice |=> pkt_valid && !pkt_hdlc && pkt_bytes == 16'(($past(bits) + 32'h7) >> 3))
    else $error("payload size wrong");
  a_left_byte: assert property ( // R17
    pkt_valid && !pkt_hdlc |-> !pkt_addr[0]
      && ((pkt_addr & ~$past(mask)) == ($past(base_q) & ~$past(mask))))
    else $error("sample address not in buffer left byte");
  a_ss_enable: assert property ( // R11
    go_voice && ssb_q == 16'h0 |=> !pkt_ss_en)
    else $error("suppression on with zero base");
  a_ts_clear: assert property ( // R20
    go_hdlc && !ev_ts_insert && tsoff_q == 32'h0 |=> pkt_ts == $past(ev_ts))
    else $error("transparent timestamp changed");
  a_seq_keep: assert property ( // R19
    go_hdlc && !ctrl_q[tvpa_pkg::C_SEQINS] |=> !pkt_seq_gen && $stable(seq_q))
    else $error("sequence generated with insert off");
  a_write_resp: assert property (
    awh_q && wh_q && !bv_q |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write not answered");
endmodule // tvpa_assembly

// file: hdl/tvpa_pkg.sv
// Constants shared by the transmit voice packet assembly block.
// Assumes a 32-bit AXI4-Lite register bus and one connection structure.
package tvpa_pkg;
  // Register byte addresses.
  localparam logic [7:0] CTRL_A = 8'h00;
  localparam logic [7:0] NEXT_A = 8'h04;
  localparam logic [7:0] SHAPE_A = 8'h08;
  localparam logic [7:0] TSOFF_A = 8'h0c;
  localparam logic [7:0] SSB_A = 8'h10;
  localparam logic [7:0] BASE_A = 8'h14;
  localparam logic [7:0] STAT_A = 8'h18;
  localparam logic [7:0] SEQ_A = 8'h1c;
  // Control field positions.
  localparam int C_VALID = 0;
  localparam int C_INIT = 1;
  localparam int C_SEQINS = 2;
  localparam int C_TSSRC = 3;
  localparam int C_BSZ = 4;
  // Shape field positions: frames, bearers, extra delay frames.
  localparam int S_FPP = 0;
  localparam int S_BEAR = 8;
  localparam int S_XDLY = 16;
  // Smallest circular buffer is 512 bytes, that is 9 address bits.
  localparam int BUF_MIN_LOG2 = 9;
  localparam logic [2:0] BSZ_MAX = 3'h3;
  // Compression rates reported by the TDM side information.
  localparam logic [2:0] R_PCM = 3'h0;
  localparam logic [2:0] R_A40 = 3'h1;
  localparam logic [2:0] R_A32 = 3'h2;
  localparam logic [2:0] R_A24 = 3'h3;
  localparam logic [2:0] R_A16 = 3'h4;
  // Payload type selector for comfort noise; 0 to 4 follow the rate.
  localparam logic [2:0] PT_CN = 3'h5;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [31:0] SHAPE_RST = 32'h0000_0101;
endpackage

// file: verification/tvpa_tdm_model.sv
// Behavioural model of the TDM writer and the scheduler event queue.
// Assumes it shares aclk with the assembly block; the bench steers it by task.
`timescale 1ns/1ns
module tvpa_tdm_model #(
  parameter int PW = 16
) (
  input wire logic aclk,
  output logic [PW-1:0] tdm_ptr,
  output logic frame_tick,
  output logic [31:0] tdm_ts,
  output logic ev_valid,
  input wire logic ev_ready,
  output logic ev_hdlc,
  output logic ev_cn,
  output logic ev_ts_insert,
  output logic [31:0] ev_ts,
  output logic [2:0] ev_rate
);
  int ticks = 0; // Frame pulses issued so far, the internal time expected.

  // Everything idles low; frames only advance when the bench asks.
  initial begin
    {frame_tick, ev_valid, ev_hdlc, ev_cn, ev_ts_insert, ev_rate, ev_ts, tdm_ts, tdm_ptr} = '0;
  end

  // Each frame pulse lasts one cycle, as the block expects.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge aclk);
      frame_tick <= 1'b1;
      @(posedge aclk);
      frame_tick <= 1'b0;
      ticks++;
    end
  endtask

  // Moves the write pointer and the slot timestamp together.
  task automatic set(input logic [PW-1:0] p, input logic [31:0] t);
    @(posedge aclk);
    tdm_ptr <= p;
    tdm_ts <= t;
  endtask

  // One event; payload holds until taken, then is scrambled so it never looks live.
  task automatic send(input logic h, input logic cn, input logic ins,
      input logic [31:0] t, input logic [2:0] r);
    @(posedge aclk);
    ev_valid <= 1'b1;
    ev_hdlc <= h;
    ev_cn <= cn;
    ev_ts_insert <= ins;
    ev_ts <= t;
    ev_rate <= r;
    do @(posedge aclk); while (ev_ready !== 1'b1);
    ev_valid <= 1'b0;
    ev_ts <= ~t;
    ev_rate <= ~r;
  endtask
endmodule // tvpa_tdm_model

// file: verification/tvpa_tb.sv
// Self-checking bench for the voice packet assembly block.
// Assumes the register map and walks given in the package and hand-over.
`timescale 1ns/1ns
module testbench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic frame_tick, ev_valid, ev_ready, ev_hdlc, ev_cn, ev_ts_insert;
  logic pkt_valid, pkt_hdlc, pkt_seq_gen, pkt_ss_en;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, tdm_ts, ev_ts, pkt_addr, pkt_ts, rd_d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic [15:0] tdm_ptr, pkt_bytes, pkt_seq;
  logic [2:0] ev_rate, pkt_pt;
  int fails = 0; // Mismatches seen.
  int checks_done = 0; // Comparisons made.
  int n_pkt = 0; // Descriptor pulses seen.
  int cyc = 0; // Cycle count for the hang guard.

  tvpa_assembly tvpa_assembly_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tdm_ptr, .frame_tick, .tdm_ts, .ev_valid, .ev_ready,
    .ev_hdlc, .ev_cn, .ev_ts_insert, .ev_ts, .ev_rate, .pkt_valid, .pkt_hdlc, .pkt_bytes,
    .pkt_addr, .pkt_ts, .pkt_pt, .pkt_seq, .pkt_seq_gen, .pkt_ss_en);
  tvpa_tdm_model tdm_i (.aclk, .tdm_ptr, .frame_tick, .tdm_ts, .ev_valid, .ev_ready,
    .ev_hdlc, .ev_cn, .ev_ts_insert, .ev_ts, .ev_rate);

  // Free-running 50 ns clock.
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Descriptor pulses last one cycle, so each edge is counted.
  always @(posedge aclk) if (pkt_valid === 1'b1) n_pkt++;

  // Hang guard: the whole run needs a few hundred cycles at most.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  // Read: data and response are taken at the edge where rvalid is seen.
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One event, then enough cycles for the one-cycle-later descriptor.
  task automatic ev(input logic h, input logic cn, input logic ins, input logic [31:0] t,
      input logic [2:0] r);
    tdm_i.send(h, cn, ins, t, r);
    repeat (3) @(posedge aclk);
  endtask

  task automatic t_regs();
    rd(tvpa_pkg::CTRL_A);
    chk("ctrl reset", rd_d, 32'h0);
    rd(tvpa_pkg::SHAPE_A);
    chk("shape reset", rd_d, tvpa_pkg::SHAPE_RST);
    rd(8'h40);
    chk("unmapped resp", {30'h0, rd_r}, {30'h0, tvpa_pkg::RESP_ERR});
    wr(tvpa_pkg::STAT_A, 32'hFFFF_FFFF);
    rd(tvpa_pkg::STAT_A);
    chk("status read only", rd_d, 32'h0);
  endtask

  // Structure not yet valid: event dropped and start-up flag left alone.
  task automatic t_invalid();
    int n0;
    wr(tvpa_pkg::SHAPE_A, 32'h0002_0103);
    wr(tvpa_pkg::NEXT_A, 32'h3);
    wr(tvpa_pkg::TSOFF_A, 32'h100);
    wr(tvpa_pkg::BASE_A, 32'h3E00);
    tdm_i.set(16'h012C, 32'h0001_0000);
    n0 = n_pkt;
    ev(1'b0, 1'b0, 1'b0, 32'h0, 3'h0);
    chk("invalid pkt", n_pkt - n0, 32'h0);
    rd(tvpa_pkg::CTRL_A);
    chk("invalid init", rd_d, 32'h0);
    rd(tvpa_pkg::STAT_A);
    chk("ignored count", {16'h0, rd_d[31:16]}, 32'h1);
  endtask

  // First valid event arms the pointer with the start-up offset.
  task automatic t_start();
    int n0;
    wr(tvpa_pkg::CTRL_A, 32'h9);
    n0 = n_pkt;
    ev(1'b0, 1'b0, 1'b0, 32'h0, 3'h0);
    chk("start pkt", n_pkt - n0, 32'h0);
    rd(tvpa_pkg::CTRL_A);
    chk("init set", {31'h0, rd_d[1]}, 32'h1);
    rd(tvpa_pkg::NEXT_A);
    chk("next armed", rd_d, 32'h12F);
  endtask

  // One frame short is ignored; exactly equal is accepted.
  task automatic t_ptr();
    int n0;
    tdm_i.set(16'h012E, 32'h0001_0000);
    n0 = n_pkt;
    ev(1'b0, 1'b0, 1'b0, 32'h0, 3'h0);
    chk("early pkt", n_pkt - n0, 32'h0);
    tdm_i.set(16'h012F, 32'h0001_0000);
    ev(1'b0, 1'b0, 1'b0, 32'h0, 3'h0);
    chk("due pkt", n_pkt - n0, 32'h1);
    rd(tvpa_pkg::NEXT_A);
    chk("next step", rd_d, 32'h132);
  endtask

  // Every rate and buffer size; 3 frames, 1 bearer, 2 extra delay frames.
  task automatic t_rates();
    logic [31:0] nxt, m, tsv, c;
    int bits[5] = '{8, 5, 4, 3, 2};
    nxt = 32'h132;
    for (int r = 0; r < 5; r++) begin
      m = (32'h200 << (r % 4)) - 1;
      c = 32'hB | ((r % 4) << 4) | ((r % 2) << 2);
      tsv = 32'h0001_0000 + r * 64;
      wr(tvpa_pkg::CTRL_A, c);
      tdm_i.set(nxt[15:0], tsv);
      ev(1'b0, 1'b0, 1'b0, 32'h0, r[2:0]);
      chk("bytes", {16'h0, pkt_bytes}, (3 * bits[r] + 7) / 8);
      chk("type", {29'h0, pkt_pt}, r);
      chk("addr", pkt_addr, (32'h3E00 & ~m) | (((nxt - 5) * 2) & m));
      chk("ts", pkt_ts, tsv - 5 + 32'h100);
      chk("seq gen", {31'h0, pkt_seq_gen}, 32'h1);
      chk("seq", {16'h0, pkt_seq}, r + 1);
      chk("ss off", {31'h0, pkt_ss_en}, 32'h0);
      nxt = nxt + 3;
    end
    tdm_i.set(nxt[15:0], tsv);
    ev(1'b0, 1'b1, 1'b0, 32'h0, 3'h0);
    chk("cn type", {29'h0, pkt_pt}, {29'h0, tvpa_pkg::PT_CN});
    wr(tvpa_pkg::SSB_A, 32'h40);
    tdm_i.set(nxt[15:0] + 16'h3, tsv);
    ev(1'b0, 1'b0, 1'b0, 32'h0, 3'h0);
    chk("ss on", {31'h0, pkt_ss_en}, 32'h1);
  endtask

  // Link-sourced packets: transparent, then added to slot and internal time.
  task automatic t_hdlc();
    wr(tvpa_pkg::TSOFF_A, 32'h0);
    wr(tvpa_pkg::CTRL_A, 32'hB);
    ev(1'b1, 1'b0, 1'b0, 32'hDEAD_BEEF, 3'h0);
    chk("hdlc flag", {31'h0, pkt_hdlc}, 32'h1);
    chk("ts pass", pkt_ts, 32'hDEAD_BEEF);
    wr(tvpa_pkg::TSOFF_A, 32'h100);
    wr(tvpa_pkg::CTRL_A, 32'hF);
    ev(1'b1, 1'b0, 1'b1, 32'h1000, 3'h0);
    chk("ts slots", pkt_ts, 32'h1000 + tdm_ts + 32'h100);
    chk("seq ins gen", {31'h0, pkt_seq_gen}, 32'h1);
    chk("seq ins", {16'h0, pkt_seq}, 32'h8);
    wr(tvpa_pkg::CTRL_A, 32'h3);
    tdm_i.tick(5);
    ev(1'b1, 1'b0, 1'b1, 32'h1000, 3'h0);
    chk("ts internal", pkt_ts, 32'h1100 + tdm_i.ticks);
    chk("seq kept", {31'h0, pkt_seq_gen}, 32'h0);
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_invalid();
    t_start();
    t_ptr();
    t_rates();
    t_hdlc();
    stop_test();
  end
endmodule // testbench
